// file: host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic CLK,
  output logic CMD_VALID,
  output status_pkg::cmd_type CMD_CODE,
  output status_pkg::set_type CMD_SET,
  output logic [15:0] CMD_DATA,
  input wire logic RSP_VALID,
  input wire logic [15:0] RSP_DATA
);
  import status_pkg::*;
  // ===========================================
  // Idle command port
  initial begin
    CMD_VALID = 1'b0;
    CMD_CODE = CMD_NOP;
    CMD_SET = SET_MEAS;
    CMD_DATA = 16'h0000;
  end
  // ===========================================
  // One command, held for one taking edge
  task automatic put(input cmd_type code, input set_type set, input logic [15:0] data);
    @(posedge CLK);
    CMD_VALID <= 1'b1;
    CMD_CODE <= code;
    CMD_SET <= set;
    CMD_DATA <= data;
    @(posedge CLK);
    CMD_VALID <= 1'b0;
    CMD_CODE <= CMD_NOP;
    // Released data shows no stale value
    CMD_DATA <= ~data;
  endtask : put
  task automatic ask(input cmd_type code, input set_type set, output logic [15:0] data);
    put(code, set, 16'h0000);
    #1;
    data = (RSP_VALID === 1'b1) ? RSP_DATA : 16'hxxxx;
  endtask : ask
endmodule : host_model
`default_nettype wire

// file: status_event_registers.sv
`timescale 1ns/1ps
`default_nettype none
module status_event_registers (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic CMD_VALID,
  input wire status_pkg::cmd_type CMD_CODE,
  input wire status_pkg::set_type CMD_SET,
  input wire logic [15:0] CMD_DATA,
  input wire logic READING_OVERFLOW,
  input wire logic BELOW_LOW_LIMIT_ONE,
  input wire logic ABOVE_HIGH_LIMIT_ONE,
  input wire logic BELOW_LOW_LIMIT_TWO,
  input wire logic ABOVE_HIGH_LIMIT_TWO,
  input wire logic READING_DONE,
  input wire logic READING_START,
  input wire logic BUFFER_AT_LEAST_TWO,
  input wire logic BUFFER_EMPTY,
  input wire logic BUFFER_HALF,
  input wire logic BUFFER_FULL_FLAG,
  input wire logic PRETRIGGER_EVENT,
  input wire logic PRETRIGGER_DONE,
  input wire logic REF_JUNCTION_INVALID,
  input wire logic REF_JUNCTION_VALID,
  input wire logic CAL_CONST_INVALID,
  input wire logic CAL_SUCCESS,
  input wire logic COMMAND_IGNORED,
  input wire logic COMMAND_EXECUTED,
  input wire logic ERR_PUSH,
  input wire logic [7:0] ERR_CODE,
  output logic RSP_VALID,
  output logic [15:0] RSP_DATA,
  output logic MEAS_SUMMARY,
  output logic QUES_SUMMARY,
  output logic ERR_INDICATOR
);
  import status_pkg::*;

  // ===========================================
  // State
  typedef struct packed {
    logic [15:0] meas_cond;
    logic [15:0] ques_cond;
    logic [15:0] meas_event;
    logic [15:0] ques_event;
    logic [15:0] meas_enable;
    logic [15:0] ques_enable;
    logic [15:0] meas_rise;
    logic [15:0] meas_fall;
    logic [15:0] ques_rise;
    logic [15:0] ques_fall;
    logic reading_ready;
    logic buffer_has_readings;
    logic buffer_pretrigger_flag;
    logic temp_bad;
    logic cal_bad;
    logic warn;
    logic [QUEUE_DEPTH-1:0][CODE_W-1:0] queue;
    logic [3:0] queue_count;
    logic [15:0] admit;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic meas_sum;
    logic ques_sum;
    logic err_led;
  } state_type;

  state_type st;
  state_type next_st;
  logic [15:0] meas_now;
  logic [15:0] ques_now;
  logic [15:0] meas_hits;
  logic [15:0] ques_hits;
  logic is_read_meas;
  logic is_read_ques;

  // ===========================================
  // Helpers
  function automatic logic [15:0] edge_hits(input logic [15:0] now, input logic [15:0] prev,
                                            input logic [15:0] rise, input logic [15:0] fall,
                                            input logic [15:0] valid);
    edge_hits = ((now & ~prev & rise) | (~now & prev & fall)) & valid;
  endfunction : edge_hits

  // Set wins over a read or clear-status clear in the same cycle
  function automatic logic [15:0] event_next(input logic [15:0] old, input logic [15:0] hits,
                                             input logic clr);
    event_next = clr ? hits : (old | hits);
  endfunction : event_next

  function automatic logic sticky(input logic old, input logic set, input logic clr);
    sticky = set | (old & ~clr);
  endfunction : sticky

  // ===========================================
  // Next state
  always_comb begin
    next_st = st;
    meas_now = '0;
    ques_now = '0;
    next_st.rsp_valid = 1'b0;
    next_st.reading_ready = sticky(st.reading_ready, READING_DONE, READING_START);
    next_st.buffer_has_readings = sticky(st.buffer_has_readings, BUFFER_AT_LEAST_TWO, BUFFER_EMPTY);
    next_st.buffer_pretrigger_flag = sticky(st.buffer_pretrigger_flag, PRETRIGGER_EVENT, PRETRIGGER_DONE);
    next_st.temp_bad = sticky(st.temp_bad, REF_JUNCTION_INVALID, REF_JUNCTION_VALID);
    next_st.cal_bad = sticky(st.cal_bad, CAL_CONST_INVALID, CAL_SUCCESS);
    next_st.warn = sticky(st.warn, COMMAND_IGNORED, COMMAND_EXECUTED);
    meas_now[BIT_OVERFLOW] = READING_OVERFLOW;
    meas_now[BIT_LOW_ONE] = BELOW_LOW_LIMIT_ONE;
    meas_now[BIT_HIGH_ONE] = ABOVE_HIGH_LIMIT_ONE;
    meas_now[BIT_LOW_TWO] = BELOW_LOW_LIMIT_TWO;
    meas_now[BIT_HIGH_TWO] = ABOVE_HIGH_LIMIT_TWO;
    meas_now[BIT_READY] = next_st.reading_ready;
    meas_now[BIT_HAS_READINGS] = next_st.buffer_has_readings;
    meas_now[BIT_HALF] = BUFFER_HALF;
    meas_now[BIT_FULL] = BUFFER_FULL_FLAG;
    meas_now[BIT_PRETRIGGER] = next_st.buffer_pretrigger_flag;
    ques_now[BIT_TEMP] = next_st.temp_bad;
    ques_now[BIT_CAL] = next_st.cal_bad;
    ques_now[BIT_WARN] = next_st.warn;
    next_st.meas_cond = meas_now;
    next_st.ques_cond = ques_now;
    // Transition filters on assigned bits only
    meas_hits = edge_hits(meas_now, st.meas_cond, st.meas_rise, st.meas_fall, MEAS_VALID_MASK);
    ques_hits = edge_hits(ques_now, st.ques_cond, st.ques_rise, st.ques_fall, QUES_VALID_MASK);
    is_read_meas = CMD_VALID && (CMD_CODE == CMD_READ_EVENT) && (CMD_SET == SET_MEAS);
    is_read_ques = CMD_VALID && (CMD_CODE == CMD_READ_EVENT) && (CMD_SET == SET_QUES);
    // Read or clear-status clears the event bits
    next_st.meas_event = event_next(st.meas_event, meas_hits,
                                    is_read_meas || (CMD_VALID && CMD_CODE == CMD_CLEAR_STATUS));
    next_st.ques_event = event_next(st.ques_event, ques_hits,
                                    is_read_ques || (CMD_VALID && CMD_CODE == CMD_CLEAR_STATUS));
    if (CMD_VALID) begin
      case (CMD_CODE)
        // Event query returns the binary weighted word
        CMD_READ_EVENT: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data = (CMD_SET == SET_MEAS) ? st.meas_event : st.ques_event;
        end
        CMD_WRITE_ENABLE: begin
          if (CMD_SET == SET_MEAS) next_st.meas_enable = CMD_DATA & MEAS_VALID_MASK;
          else next_st.ques_enable = CMD_DATA & QUES_VALID_MASK;
        end
        CMD_READ_ENABLE: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data = (CMD_SET == SET_MEAS) ? st.meas_enable : st.ques_enable;
        end
        CMD_WRITE_RISE: begin
          if (CMD_SET == SET_MEAS) next_st.meas_rise = CMD_DATA & MEAS_VALID_MASK;
          else next_st.ques_rise = CMD_DATA & QUES_VALID_MASK;
        end
        CMD_READ_RISE: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data = (CMD_SET == SET_MEAS) ? st.meas_rise : st.ques_rise;
        end
        CMD_WRITE_FALL: begin
          if (CMD_SET == SET_MEAS) next_st.meas_fall = CMD_DATA & MEAS_VALID_MASK;
          else next_st.ques_fall = CMD_DATA & QUES_VALID_MASK;
        end
        CMD_READ_FALL: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data = (CMD_SET == SET_MEAS) ? st.meas_fall : st.ques_fall;
        end
        CMD_READ_COND: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data = (CMD_SET == SET_MEAS) ? st.meas_cond : st.ques_cond;
        end
        // Preset restores masks and filters only
        CMD_PRESET: begin
          next_st.meas_enable = ENABLE_DEFAULT;
          next_st.ques_enable = ENABLE_DEFAULT;
          next_st.meas_rise = MEAS_VALID_MASK;
          next_st.ques_rise = QUES_VALID_MASK;
          next_st.meas_fall = FALL_DEFAULT;
          next_st.ques_fall = FALL_DEFAULT;
        end
        // Newest message leaves first; empty answers no-error
        CMD_QUEUE_NEXT: begin
          next_st.rsp_valid = 1'b1;
          if (st.queue_count != 4'h0) begin
            next_st.rsp_data = {8'h00, st.queue[QIDX_W'(st.queue_count - 4'h1)]};
            next_st.queue_count = st.queue_count - 4'h1;
          end else begin
            next_st.rsp_data = {8'h00, NO_ERROR_CODE};
          end
        end
        CMD_QUEUE_ADMIT: next_st.admit = st.admit | CMD_DATA;
        CMD_QUEUE_BLOCK: next_st.admit = st.admit & ~CMD_DATA;
        CMD_QUEUE_READ_ADMIT: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data = st.admit;
        end
        CMD_QUEUE_CLEAR: next_st.queue_count = 4'h0;
        default: begin
        end
      endcase
    end
    // Admission filter on the low code nibble; a full queue drops new messages
    if (ERR_PUSH && st.admit[ERR_CODE[ADMIT_SEL_W-1:0]] && !(CMD_VALID && CMD_CODE == CMD_QUEUE_CLEAR)
        && (next_st.queue_count != QUEUE_FULL_COUNT)) begin
      next_st.queue[QIDX_W'(next_st.queue_count)] = ERR_CODE;
      next_st.queue_count = next_st.queue_count + 4'h1;
    end
    next_st.meas_sum = |(next_st.meas_event & next_st.meas_enable);
    next_st.ques_sum = |(next_st.ques_event & next_st.ques_enable);
    next_st.err_led = |ques_now;
  end

  // ===========================================
  // Registers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      st <= '0;
      // Reset clears events and loads defaults
      st.meas_event <= EVENT_RESET;
      st.ques_event <= EVENT_RESET;
      st.meas_rise <= MEAS_VALID_MASK;
      st.ques_rise <= QUES_VALID_MASK;
      st.admit <= ADMIT_DEFAULT;
    end else if (CE) begin
      st <= next_st;
    end
  end

  assign RSP_VALID = st.rsp_valid;
  assign RSP_DATA = st.rsp_data;
  assign MEAS_SUMMARY = st.meas_sum;
  assign QUES_SUMMARY = st.ques_sum;
  assign ERR_INDICATOR = st.err_led;

  // ===========================================
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  read_value_a : assert property (
    (CE && is_read_meas) |=> (RSP_VALID && RSP_DATA == $past(st.meas_event)))
    else $error("event query returned wrong word");
  read_clear_a : assert property (
    (CE && is_read_ques && ques_hits == 16'h0000) |=> (st.ques_event == 16'h0000))
    else $error("event register not cleared by query");
  reset_clear_a : assert property (
    $past(SRST) |-> (st.meas_event == 16'h0000 && st.ques_event == 16'h0000))
    else $error("events not cleared by reset");
  clear_status_a : assert property (
    (CE && CMD_VALID && CMD_CODE == CMD_CLEAR_STATUS && meas_hits == 16'h0000)
    |=> (st.meas_event == 16'h0000))
    else $error("clear-status left event bits");
  preset_keep_a : assert property (
    (CE && CMD_VALID && CMD_CODE == CMD_PRESET)
    |=> (st.meas_event == ($past(st.meas_event) | $past(meas_hits)) && st.meas_enable == 16'h0000))
    else $error("preset disturbed events or kept enables");
  rise_set_a : assert property (
    (CE && |(meas_now & ~st.meas_cond & st.meas_rise))
    |=> ((st.meas_event & $past(meas_now & ~st.meas_cond & st.meas_rise))
         == $past(meas_now & ~st.meas_cond & st.meas_rise)))
    else $error("rising transition missed");
  fall_set_a : assert property (
    (CE && |(~ques_now & st.ques_cond & st.ques_fall))
    |=> ((st.ques_event & $past(~ques_now & st.ques_cond & st.ques_fall))
         == $past(~ques_now & st.ques_cond & st.ques_fall)))
    else $error("falling transition missed");
  unused_zero_a : assert property (
    ((st.meas_event & ~MEAS_VALID_MASK) == 16'h0000) && ((st.ques_event & ~QUES_VALID_MASK) == 16'h0000))
    else $error("unassigned event bit set");
  summary_mask_a : assert property (
    MEAS_SUMMARY == |(st.meas_event & st.meas_enable))
    else $error("measurement summary mismatch");
  err_led_a : assert property (
    (CE && REF_JUNCTION_INVALID) |=> ERR_INDICATOR)
    else $error("error indicator not lit");
  ready_track_a : assert property (
    (CE && READING_DONE) |=> st.meas_cond[BIT_READY])
    else $error("reading ready not set");

  read_seen_c : cover property (CE && is_read_meas && st.meas_event != 16'h0000);
  fall_seen_c : cover property (CE && |(~ques_now & st.ques_cond & st.ques_fall));
  queue_full_c : cover property (st.queue_count == QUEUE_FULL_COUNT);
  collide_c : cover property (CE && is_read_meas && meas_hits != 16'h0000);
endmodule : status_event_registers
`default_nettype wire

// file: status_event_registers_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: status_pkg.sv
`default_nettype none
package status_pkg;
  // ===========================================
  // Sizes
  localparam int WORD_W = 16;
  localparam int CODE_W = 8;
  localparam int QUEUE_DEPTH = 8;
  localparam int QIDX_W = 3;
  localparam logic [3:0] QUEUE_FULL_COUNT = 4'h8;
  localparam int ADMIT_SEL_W = 4;

  // ===========================================
  // Measurement set bit positions
  localparam int BIT_OVERFLOW = 0;
  localparam int BIT_LOW_ONE = 1;
  localparam int BIT_HIGH_ONE = 2;
  localparam int BIT_LOW_TWO = 3;
  localparam int BIT_HIGH_TWO = 4;
  localparam int BIT_READY = 5;
  localparam int BIT_HAS_READINGS = 7;
  localparam int BIT_HALF = 8;
  localparam int BIT_FULL = 9;
  localparam int BIT_PRETRIGGER = 11;

  // ===========================================
  // Questionable set bit positions
  localparam int BIT_TEMP = 4;
  localparam int BIT_CAL = 8;
  localparam int BIT_WARN = 14;

  // ===========================================
  // Masks and reset values
  localparam logic [15:0] MEAS_VALID_MASK = 16'h0BBF;
  localparam logic [15:0] QUES_VALID_MASK = 16'h4110;
  localparam logic [15:0] EVENT_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_DEFAULT = 16'h0000;
  localparam logic [15:0] FALL_DEFAULT = 16'h0000;
  localparam logic [15:0] ADMIT_DEFAULT = 16'hFFFF;
  localparam logic [7:0] NO_ERROR_CODE = 8'h00;

  // ===========================================
  // Commands
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_READ_EVENT = 4'h1,
    CMD_WRITE_ENABLE = 4'h2,
    CMD_READ_ENABLE = 4'h3,
    CMD_WRITE_RISE = 4'h4,
    CMD_READ_RISE = 4'h5,
    CMD_WRITE_FALL = 4'h6,
    CMD_READ_FALL = 4'h7,
    CMD_READ_COND = 4'h8,
    CMD_PRESET = 4'h9,
    CMD_CLEAR_STATUS = 4'hA,
    CMD_QUEUE_NEXT = 4'hB,
    CMD_QUEUE_ADMIT = 4'hC,
    CMD_QUEUE_READ_ADMIT = 4'hD,
    CMD_QUEUE_BLOCK = 4'hE,
    CMD_QUEUE_CLEAR = 4'hF
  } cmd_type;

  typedef enum logic {
    SET_MEAS = 1'b0,
    SET_QUES = 1'b1
  } set_type;
endpackage : status_pkg
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import status_pkg::*;
  logic clk, srst, ce, cmd_valid, rsp_valid, meas_summary, ques_summary, err_indicator, err_push;
  cmd_type cmd_code;
  set_type cmd_set, sel;
  logic [15:0] cmd_data, rsp_data, got;
  logic [6:0] lvl, pick;
  logic [11:0] pul;
  logic [7:0] err_code;
  logic [31:0] lfsr;
  int miscompares, comparisons;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  host_model host (.CLK(clk), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_SET(cmd_set),
    .CMD_DATA(cmd_data), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));

  status_event_registers dut (.CLK(clk), .SRST(srst), .CE(ce), .CMD_VALID(cmd_valid),
    .CMD_CODE(cmd_code), .CMD_SET(cmd_set), .CMD_DATA(cmd_data), .READING_OVERFLOW(lvl[0]),
    .BELOW_LOW_LIMIT_ONE(lvl[1]), .ABOVE_HIGH_LIMIT_ONE(lvl[2]), .BELOW_LOW_LIMIT_TWO(lvl[3]),
    .ABOVE_HIGH_LIMIT_TWO(lvl[4]), .BUFFER_HALF(lvl[5]), .BUFFER_FULL_FLAG(lvl[6]),
    .READING_DONE(pul[0]), .READING_START(pul[1]), .BUFFER_AT_LEAST_TWO(pul[2]),
    .BUFFER_EMPTY(pul[3]), .PRETRIGGER_EVENT(pul[4]), .PRETRIGGER_DONE(pul[5]),
    .REF_JUNCTION_INVALID(pul[6]), .REF_JUNCTION_VALID(pul[7]), .CAL_CONST_INVALID(pul[8]),
    .CAL_SUCCESS(pul[9]), .COMMAND_IGNORED(pul[10]), .COMMAND_EXECUTED(pul[11]),
    .ERR_PUSH(err_push), .ERR_CODE(err_code), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
    .MEAS_SUMMARY(meas_summary), .QUES_SUMMARY(ques_summary), .ERR_INDICATOR(err_indicator));

  // ===========================================
  // Helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic [15:0] meas_of(input logic [6:0] l);
    meas_of = 16'h0000;
    meas_of[4:0] = l[4:0];
    meas_of[BIT_HALF] = l[5];
    meas_of[BIT_FULL] = l[6];
  endfunction : meas_of

  task automatic conclude;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic expect_q(input cmd_type c, input set_type s, input logic [15:0] exp, input string name);
    host.ask(c, s, got);
    check(name, exp, got);
  endtask : expect_q

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic pulse(input logic [11:0] m);
    @(posedge clk);
    pul <= m;
    @(posedge clk);
    pul <= 12'h000;
    idle(3);
  endtask : pulse

  task automatic push(input logic [7:0] c);
    @(posedge clk);
    err_push <= 1'b1;
    err_code <= c;
    @(posedge clk);
    err_push <= 1'b0;
    err_code <= ~c;
  endtask : push

  // ===========================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end

  // ===========================================
  // Main sequence
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    lvl = 7'h00;
    pul = 12'h000;
    err_push = 1'b0;
    err_code = 8'h00;
    miscompares = 0;
    comparisons = 0;
    lfsr = 32'h0000_a71c;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      sel = set_type'(s);
      expect_q(CMD_READ_EVENT, sel, EVENT_RESET, "event");
      expect_q(CMD_READ_ENABLE, sel, ENABLE_DEFAULT, "enable");
      expect_q(CMD_READ_RISE, sel, (s == 1) ? QUES_VALID_MASK : MEAS_VALID_MASK, "rise");
      expect_q(CMD_READ_FALL, sel, FALL_DEFAULT, "fall");
    end
    // Random level conditions, rising then falling
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      pick = (i == 0) ? 7'h7f : lfsr[6:0];
      @(posedge clk);
      lvl <= pick;
      idle(2);
      expect_q(CMD_READ_COND, SET_MEAS, meas_of(pick), "condition");
      expect_q(CMD_READ_EVENT, SET_MEAS, meas_of(pick), "rise event");
      expect_q(CMD_READ_EVENT, SET_MEAS, 16'h0000, "cleared event");
      host.put(CMD_WRITE_FALL, SET_MEAS, 16'hffff);
      host.put(CMD_WRITE_RISE, SET_MEAS, 16'h0000);
      expect_q(CMD_READ_FALL, SET_MEAS, MEAS_VALID_MASK, "fall mask");
      @(posedge clk);
      lvl <= 7'h00;
      idle(2);
      expect_q(CMD_READ_EVENT, SET_MEAS, meas_of(pick), "fall event");
      host.put(CMD_PRESET, SET_MEAS, 16'h0000);
    end
    // Sticky conditions, summaries and preset
    pulse(12'h555);
    check("indicator", 16'h0001, {15'h0000, err_indicator});
    expect_q(CMD_READ_COND, SET_QUES, QUES_VALID_MASK, "ques condition");
    host.put(CMD_WRITE_ENABLE, SET_MEAS, 16'h0020);
    host.put(CMD_WRITE_ENABLE, SET_QUES, 16'h0010);
    idle(2);
    check("meas summary", 16'h0001, {15'h0000, meas_summary});
    check("ques summary", 16'h0001, {15'h0000, ques_summary});
    host.put(CMD_PRESET, SET_MEAS, 16'h0000);
    expect_q(CMD_READ_ENABLE, SET_MEAS, ENABLE_DEFAULT, "preset enable");
    idle(2);
    check("masked summary", 16'h0000, {15'h0000, meas_summary});
    expect_q(CMD_READ_EVENT, SET_MEAS, 16'h08a0, "pulse event");
    expect_q(CMD_READ_EVENT, SET_QUES, QUES_VALID_MASK, "ques event");
    host.put(CMD_WRITE_FALL, SET_QUES, 16'hffff);
    pulse(12'haaa);
    check("indicator off", 16'h0000, {15'h0000, err_indicator});
    expect_q(CMD_READ_COND, SET_QUES, 16'h0000, "ques released");
    host.put(CMD_CLEAR_STATUS, SET_MEAS, 16'h0000);
    expect_q(CMD_READ_EVENT, SET_QUES, EVENT_RESET, "cleared ques");
    // Clock enable low: a command in that window is lost
    ce <= 1'b0;
    host.put(CMD_WRITE_ENABLE, SET_MEAS, 16'h0020);
    @(posedge clk);
    ce <= 1'b1;
    expect_q(CMD_READ_ENABLE, SET_MEAS, ENABLE_DEFAULT, "frozen enable");
    // Error queue: overfill, newest first, block and clear
    for (int i = 0; i < 9; i++) begin
      push(8'(i + 1));
    end
    for (int i = 8; i >= 0; i--) begin
      expect_q(CMD_QUEUE_NEXT, SET_MEAS, 16'(i), "queue entry");
    end
    host.put(CMD_QUEUE_BLOCK, SET_MEAS, 16'h0020);
    expect_q(CMD_QUEUE_READ_ADMIT, SET_MEAS, 16'hffdf, "admit list");
    push(8'h15);
    push(8'h07);
    expect_q(CMD_QUEUE_NEXT, SET_MEAS, 16'h0007, "admitted");
    expect_q(CMD_QUEUE_NEXT, SET_MEAS, 16'h0000, "blocked");
    host.put(CMD_QUEUE_ADMIT, SET_MEAS, 16'h0020);
    push(8'h25);
    expect_q(CMD_QUEUE_NEXT, SET_MEAS, 16'h0025, "readmitted");
    push(8'h09);
    host.put(CMD_QUEUE_CLEAR, SET_MEAS, 16'h0000);
    expect_q(CMD_QUEUE_NEXT, SET_MEAS, 16'h0000, "cleared queue");
    // Read and a new rising edge in one cycle: the new bit survives the clear
    fork
      expect_q(CMD_READ_EVENT, SET_MEAS, 16'h0000, "collide read");
      begin
        @(posedge clk);
        lvl <= 7'h01;
      end
    join
    expect_q(CMD_READ_EVENT, SET_MEAS, 16'h0001, "collide keep");
    // Mid-run reset with an event and a queue entry pending
    @(posedge clk);
    lvl <= 7'h02;
    push(8'h03);
    srst <= 1'b1;
    lvl <= 7'h00;
    idle(2);
    srst <= 1'b0;
    expect_q(CMD_READ_EVENT, SET_MEAS, EVENT_RESET, "reset event");
    expect_q(CMD_QUEUE_NEXT, SET_MEAS, 16'h0000, "reset queue");
    conclude();
  end
endmodule : testbench
`default_nettype wire
